// File: inc/sod_pkg.sv
// Operation
// [R1] Order bit 0 raises an interrupt request
// [R2] Count done leads to order-in reporting channel end
// [R3] Chain bit read only after channel end
// [R4] Chain clear after channel end returns ready
// [R5] Pending interrupt refuses start until acknowledged
// [R6] Chain set fetches next command by order-out
// [R7] Processor halt reports abnormal end via order-in
// [R8] Order bits above 3 carry no meaning
// [R9] Dummy order accepted, not counted as data
// [R10] Without chaining, each operation ends at ready
// [R11] Eight-bit multiplexer serves up to 32 controllers
// [R12] Wide multiplexer serves up to 24 controllers
// [R13] Selector processor keeps one controller busy
// [R14] After abnormal end, ready on order strobe
// [R15] Halt in order-in order goes straight ready
// [R16] Order byte captured, bits decoded same cycle
package sod_pkg;

	// Service order bit positions
	localparam int ORD_INTR_BIT  = 0;
	localparam int ORD_DONE_BIT  = 1;
	localparam int ORD_CHAIN_BIT = 2;
	localparam int ORD_HALT_BIT  = 3;
	localparam int ORDER_W       = 8;
	localparam int CNT_W         = 16;

	// Register offsets, byte addresses on the plain port
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATE  = 8'h04;
	localparam logic [7:0] OFF_EVENTS = 8'h08;
	localparam logic [7:0] OFF_MASK   = 8'h0C;
	localparam logic [7:0] OFF_COUNT  = 8'h10;

	// Control register fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_ABORT_BIT  = 1;

	// Event bits, shared by status and mask
	localparam int EV_W         = 6;
	localparam int EV_START_OK  = 0;
	localparam int EV_START_NO  = 1;
	localparam int EV_CHANNEL_END_FLAG     = 2;
	localparam int EV_ABNORMAL_END_FLAG      = 3;
	localparam int EV_READY     = 4;
	localparam int EV_INTR      = 5;

	// Values after reset
	localparam logic [EV_W-1:0] RST_MASK   = 6'h00;
	localparam logic            RST_ENABLE = 1'b1;

	// Controller sequence
	typedef enum logic [2:0] {
		ST_READY,
		ST_FETCH,
		ST_DATA,
		ST_CHANNEL_END_FLAG,
		ST_ABNORMAL_END_FLAG
	} state_e;

	// Kind of service cycle requested
	typedef enum logic [1:0] {
		SVC_NONE,
		SVC_ORDER_OUT,
		SVC_ORDER_IN,
		SVC_DATA
	} svc_kind_e;

	// Request towards the io_processor
	typedef struct packed {
		logic      req;
		svc_kind_e kind;
		logic      channel_end_flag;
		logic      abnormal_end_flag;
	} svc_s;

	// Service order from the io_processor
	typedef struct packed {
		logic               valid;
		logic [ORDER_W-1:0] service_order_byte;
		logic               xfer;
	} order_s;

	// Plain register port from software
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

endpackage

// File: logic/event_irq.sv
`timescale 1ns/1ps
// Sticky event status with mask and one level interrupt
module event_irq
	import sod_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            srst,
	input  wire logic [EV_W-1:0] ev_set,
	input  wire logic            status_wr,
	input  wire logic            mask_wr,
	input  wire logic [EV_W-1:0] wdata,
	output logic      [EV_W-1:0] status,
	output logic      [EV_W-1:0] mask,
	output logic                 irq
);

	// All state of this module
	typedef struct packed {
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
	} irq_s;

	irq_s q;   // Registered state
	irq_s d;   // Next state

	// Set wins over a write-one clear in the same cycle
	always_comb begin
		d = q;
		if (status_wr) begin
			d.status = q.status & ~wdata;
		end
		d.status = d.status | ev_set;
		if (mask_wr) begin
			d.mask = wdata;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			q.status <= '0;
			q.mask   <= RST_MASK;
		end else begin
			q <= d;
		end
	end

	assign status = q.status;
	assign mask   = q.mask;
	assign irq    = |(q.status & q.mask);

	// Event must stay set after a clash with clear
	set_wins_a: assert property (@(posedge core_clk) disable iff (srst)
		|ev_set |=> (q.status & $past(ev_set)) == $past(ev_set))
		else $error("event lost against clear");

endmodule

// File: logic/service_order_decoder.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Device controller sequencer driven by the io_processor's service orders
module service_order_decoder
	import sod_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire order_s      order,
	output svc_s             svc,
	input  wire logic        start_instruction,
	input  wire logic        halt_instruction,
	input  wire logic        interrupt_ack_instruction,
	output logic             start_accepted,
	output logic             start_refused,
	output logic             device_int_req,
	output logic             device_busy,
	input  wire reg_req_s    reg_req,
	output logic [31:0]      reg_rdata,
	output logic             irq
);

	// All controller state
	typedef struct packed {
		state_e             st;
		logic               int_pend;
		logic [ORDER_W-1:0] last_order;
		logic [CNT_W-1:0]   xfer_cnt;
		logic               enable;
		logic               start_ok;
		logic               start_no;
		logic [31:0]        rdata;
	} ctl_s;

	ctl_s q;                     // Registered state
	ctl_s d;                     // Next state
	logic [EV_W-1:0] ev;         // Events this cycle
	logic [EV_W-1:0] ev_status;  // Sticky events, for readback
	logic [EV_W-1:0] ev_mask;    // Mask, for readback
	logic            ord_intr;   // Decoded order bits
	logic            ord_done;
	logic            ord_chain;
	logic            ord_halt;
	logic            wr_ctrl;    // Write decodes
	logic            wr_events;
	logic            wr_mask;

	// One bit of the service order
	function automatic logic ord_bit(input logic [ORDER_W-1:0] b, input int pos);
		ord_bit = b[pos];
	endfunction

	// Busy states, where an abort has something to end
	function automatic logic is_busy(input state_e s);
		is_busy = (s == ST_FETCH) || (s == ST_DATA) || (s == ST_CHANNEL_END_FLAG);
	endfunction

	// Only bits 0 to 3 are decoded; upper bits never looked at
	assign ord_intr  = order.valid && ord_bit(order.service_order_byte, ORD_INTR_BIT);   // [R8]
	assign ord_done  = order.valid && ord_bit(order.service_order_byte, ORD_DONE_BIT);   // [R8]
	assign ord_chain = order.valid && ord_bit(order.service_order_byte, ORD_CHAIN_BIT);  // [R8]
	assign ord_halt  = order.valid && ord_bit(order.service_order_byte, ORD_HALT_BIT);   // [R8]

	// Register write strobes
	assign wr_ctrl   = reg_req.wr && (reg_req.addr == OFF_CTRL);
	assign wr_events = reg_req.wr && (reg_req.addr == OFF_EVENTS);
	assign wr_mask   = reg_req.wr && (reg_req.addr == OFF_MASK);

	// Next-state logic: halt instruction, then orders, then starts
	always_comb begin
		d          = q;
		ev         = '0;
		d.start_ok = 1'b0;
		d.start_no = 1'b0;

		// Order byte kept once per service cycle
		if (order.valid) begin
			d.last_order = order.service_order_byte;  // [R16]
		end

		// Interrupt bit changes nothing else by itself
		if (ord_intr) begin
			d.int_pend = 1'b1;  // [R1]
			ev[EV_INTR] = 1'b1;
		end

		// Dummy orders move no data, so only real bytes count
		if (order.valid && order.xfer && (q.st == ST_DATA)) begin
			d.xfer_cnt = q.xfer_cnt + CNT_W'(1);  // [R9]
		end

		if (halt_instruction) begin
			// Halt instruction: straight to ready, pending kept
			d.st = ST_READY;
			if (q.st != ST_READY) begin
				ev[EV_READY] = 1'b1;
			end
		end else begin
			case (q.st)
				// Idle; orders here are dummies
				ST_READY: begin
					if (start_instruction) begin
						if (q.int_pend || !q.enable) begin
							d.start_no = 1'b1;  // [R5]
							ev[EV_START_NO] = 1'b1;
						end else begin
							d.st       = ST_FETCH;
							d.start_ok = 1'b1;
							d.xfer_cnt = '0;
							ev[EV_START_OK] = 1'b1;
						end
					end
				end
				// Order-out to get the command
				ST_FETCH: begin
					if (ord_halt) begin
						d.st = ST_ABNORMAL_END_FLAG;  // [R7]
					end else if (order.valid) begin
						d.st = ST_DATA;  // [R3]
					end
				end
				// Data service cycles
				ST_DATA: begin
					if (ord_halt) begin
						d.st = ST_ABNORMAL_END_FLAG;  // [R7]
					end else if (ord_done) begin
						d.st = ST_CHANNEL_END_FLAG;  // [R2]
					end
				end
				// Order-in reporting channel end; its order is inspected for chaining
				ST_CHANNEL_END_FLAG: begin
					if (order.valid) begin
						ev[EV_CHANNEL_END_FLAG] = 1'b1;
						if (ord_halt) begin
							d.st = ST_READY;  // [R15]
							ev[EV_READY] = 1'b1;
						end else if (ord_chain) begin
							d.st = ST_FETCH;  // [R6]
						end else begin
							d.st = ST_READY;  // [R4] [R10]
							ev[EV_READY] = 1'b1;
						end
					end
				end
				// Order-in reporting abnormal end; the order's strobe ends it
				ST_ABNORMAL_END_FLAG: begin
					if (order.valid) begin
						d.st = ST_READY;  // [R14] [R15]
						ev[EV_ABNORMAL_END_FLAG]  = 1'b1;
						ev[EV_READY] = 1'b1;
					end
				end
				default: begin
					d.st = ST_READY;
				end
			endcase
			// Software abort ends a busy operation with abnormal end
			if (wr_ctrl && reg_req.wdata[CTRL_ABORT_BIT] && is_busy(q.st) && !order.valid) begin
				d.st = ST_ABNORMAL_END_FLAG;  // [R7]
			end
		end

		// Acknowledge clears; a new interrupt bit in the same cycle wins
		if (interrupt_ack_instruction && !ord_intr) begin
			d.int_pend = 1'b0;  // [R5]
		end

		// Control register
		if (wr_ctrl) begin
			d.enable = reg_req.wdata[CTRL_ENABLE_BIT];
		end

		// Read data, valid in the cycle after the strobe only
		d.rdata = '0;
		if (reg_req.rd) begin
			case (reg_req.addr)
				OFF_CTRL:   d.rdata = {31'h0, q.enable};
				OFF_STATE:  d.rdata = {20'h0, q.last_order, q.int_pend, q.st};
				OFF_EVENTS: d.rdata = {26'h0, ev_status};
				OFF_MASK:   d.rdata = {26'h0, ev_mask};
				OFF_COUNT:  d.rdata = {16'h0, q.xfer_cnt};
				default:    d.rdata = 32'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			q.st         <= ST_READY;
			q.int_pend   <= 1'b0;
			q.last_order <= '0;
			q.xfer_cnt   <= '0;
			q.enable     <= RST_ENABLE;
			q.start_ok   <= 1'b0;
			q.start_no   <= 1'b0;
			q.rdata      <= '0;
		end else begin
			q <= d;
		end
	end

	// Service request follows the state; none while ready
	always_comb begin
		svc = '{req: 1'b0, kind: SVC_NONE, channel_end_flag: 1'b0, abnormal_end_flag: 1'b0};
		case (q.st)
			ST_FETCH: begin
				svc.req  = 1'b1;
				svc.kind = SVC_ORDER_OUT;  // [R6]
			end
			ST_DATA: begin
				svc.req  = 1'b1;
				svc.kind = SVC_DATA;
			end
			ST_CHANNEL_END_FLAG: begin
				svc.req              = 1'b1;
				svc.kind             = SVC_ORDER_IN;  // [R2]
				svc.channel_end_flag = 1'b1;
			end
			ST_ABNORMAL_END_FLAG: begin
				// Channel end set too, for consistency
				svc.req               = 1'b1;
				svc.kind              = SVC_ORDER_IN;  // [R7]
				svc.channel_end_flag  = 1'b1;
				svc.abnormal_end_flag = 1'b1;
			end
			default: begin
				svc.req = 1'b0;  // [R4]
			end
		endcase
	end

	// Interrupt request runs beside any order-out request
	assign device_int_req = q.int_pend;  // [R1] [R6]
	assign device_busy    = q.st != ST_READY;
	assign start_accepted = q.start_ok;
	assign start_refused  = q.start_no;
	assign reg_rdata      = q.rdata;

	// Sticky event status, mask and interrupt line
	event_irq u_irq (
		.core_clk  (core_clk),
		.srst      (srst),
		.ev_set    (ev),
		.status_wr (wr_events),
		.mask_wr   (wr_mask),
		.wdata     (reg_req.wdata[EV_W-1:0]),
		.status    (ev_status),
		.mask      (ev_mask),
		.irq       (irq)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// Interrupt bit in any order raises the request
	intr_raise_a: assert property (ord_intr |=> device_int_req)  // [R1]
		else $error("interrupt bit not raised");
	// Count done in data asks for the channel-end order-in
	channel_end_flag_request_a: assert property (  // [R2]
		(q.st == ST_DATA) && ord_done && !ord_halt && !halt_instruction
		|=> svc.req && (svc.kind == SVC_ORDER_IN) && svc.channel_end_flag)
		else $error("no order-in for channel end");
	// Chain bit in a data order changes nothing
	chain_ignored_a: assert property (  // [R3]
		(q.st == ST_DATA) && ord_chain && !ord_done && !ord_halt && !halt_instruction
		&& !wr_ctrl |=> q.st == ST_DATA)
		else $error("chain bit acted on outside channel end");
	// Quiet after channel end without chaining; a new start may follow
	chain_clear_a: assert property (  // [R4]
		(q.st == ST_CHANNEL_END_FLAG) && order.valid && !ord_chain && !ord_halt
		|=> !svc.req ##1 (!svc.req || start_accepted))
		else $error("no return to ready");
	// Pending interrupt blocks a start
	start_refused_a: assert property (  // [R5]
		(q.st == ST_READY) && q.int_pend && start_instruction && !halt_instruction
		|=> start_refused && !device_busy)
		else $error("start taken while interrupt pending");
	// Chained order fetches the next command beside the interrupt
	chain_fetch_a: assert property (  // [R6]
		(q.st == ST_CHANNEL_END_FLAG) && ord_chain && !ord_halt && !halt_instruction
		|=> (svc.kind == SVC_ORDER_OUT) && (device_int_req == $past(ord_intr)
		|| $past(q.int_pend)))
		else $error("chain did not fetch next command");
	// Processor halt ends data with abnormal end
	halt_abnormal_end_flag_a: assert property (  // [R7]
		(q.st == ST_DATA) && ord_halt && !halt_instruction
		|=> svc.abnormal_end_flag && (svc.kind != SVC_DATA))
		else $error("halt did not report abnormal end");
	// Upper bits alone leave data and interrupt untouched
	upper_bits_a: assert property (  // [R8]
		(q.st == ST_DATA) && order.valid && (order.service_order_byte[3:0] == 4'h0)
		&& !halt_instruction && !wr_ctrl && !interrupt_ack_instruction
		|=> (q.st == ST_DATA) && $stable(q.int_pend))
		else $error("upper order bits changed behaviour");
	// Dummy orders leave the byte count alone
	dummy_count_a: assert property (order.valid && !order.xfer && !start_accepted  // [R9]
		&& !(start_instruction && q.st == ST_READY) |=> $stable(q.xfer_cnt))
		else $error("dummy order counted as data");
	// Abnormal-end order brings ready at once
	abnormal_end_flag_ready_a: assert property (  // [R14]
		(q.st == ST_ABNORMAL_END_FLAG) && order.valid |=> !device_busy ##1 !svc.abnormal_end_flag)
		else $error("not ready after abnormal end");
	// Halt in the channel-end order gives no abnormal end
	halt_in_oin_a: assert property (  // [R15]
		(q.st == ST_CHANNEL_END_FLAG) && ord_halt |=> !svc.req && !svc.abnormal_end_flag)
		else $error("abnormal end regenerated");
	// Order byte held for readback
	order_capture_a: assert property (order.valid  // [R16]
		|=> q.last_order == $past(order.service_order_byte))
		else $error("order byte not captured");

	// Starts, halts, abort and read data
	// Accepted start goes straight to the command fetch
	start_fetch_a: assert property (  // [R4]
		(q.st == ST_READY) && start_instruction && !q.int_pend && q.enable
		&& !halt_instruction |=> start_accepted && svc.req && (svc.kind == SVC_ORDER_OUT))
		else $error("accepted start did not fetch");
	// Disabled controller refuses a start and stays ready
	start_disabled_a: assert property (
		(q.st == ST_READY) && !q.enable && start_instruction && !halt_instruction
		|=> start_refused && !device_busy)
		else $error("start taken while disabled");
	// Software abort of a busy operation reports abnormal end
	abort_abnormal_end_flag_a: assert property (  // [R7]
		wr_ctrl && reg_req.wdata[CTRL_ABORT_BIT] && is_busy(q.st) && !order.valid
		&& !halt_instruction |=> svc.abnormal_end_flag && (svc.kind == SVC_ORDER_IN))
		else $error("abort did not report abnormal end");
	// Halt instruction reaches ready in one edge
	halt_ready_a: assert property (halt_instruction |=> !device_busy && !svc.req)
		else $error("halt instruction did not reach ready");
	// Halt instruction keeps a pending interrupt
	halt_keeps_int_a: assert property (
		halt_instruction && q.int_pend && !interrupt_ack_instruction |=> device_int_req)
		else $error("pending interrupt lost on halt");
	// Read data stands only in the cycle after the strobe
	rdata_idle_a: assert property (!reg_req.rd |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");

	// Main scenarios
	channel_end_flag_ready_c: cover property ((q.st == ST_DATA) ##1 (q.st == ST_CHANNEL_END_FLAG) ##[1:20] (q.st == ST_READY));
	chain_c: cover property ((q.st == ST_CHANNEL_END_FLAG) ##1 (q.st == ST_FETCH));
	abnormal_end_flag_c: cover property ((q.st == ST_ABNORMAL_END_FLAG) ##[1:20] (q.st == ST_READY));
	refuse_c: cover property (start_refused);
	abort_c: cover property (wr_ctrl && reg_req.wdata[CTRL_ABORT_BIT] && is_busy(q.st));

endmodule

// File: sim/iop_model.sv
`timescale 1ns/1ps
// Behavioural io_processor: answers one armed service cycle at a time
module iop_model
	import sod_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               srst,
	input  wire svc_s               svc,
	input  wire logic               arm,
	input  wire logic [ORDER_W-1:0] next_byte,
	input  wire logic               next_xfer,
	input  wire logic [1:0]         wait_n,
	output order_s                  order
);
	logic       pend_q; // Armed order waiting for a request
	logic [1:0] cnt_q;  // Stall cycles still to go
	// Order lines toggle between orders, so stale bytes never look valid
	always_ff @(posedge core_clk) begin
		order.valid <= 1'b0;
		order.xfer <= ~order.xfer;
		order.service_order_byte <= ~order.service_order_byte;
		if (srst) begin
			pend_q <= 1'b0;
			cnt_q <= 2'h0;
			order <= '0;
		end else if (pend_q && svc.req) begin // Serves this one controller
			if (cnt_q == 2'h0) begin
				order <= '{1'b1, next_byte, next_xfer}; // Bench picks the bits
				pend_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 2'h1; // Slow answer
			end
		end else if (arm) begin
			pend_q <= 1'b1;
			cnt_q <= wait_n;
		end
	end
endmodule

// File: sim/service_order_decoder_test.sv
`timescale 1ns/1ps
// Self-checking bench for the service order sequencer
module service_order_decoder_test;
	import sod_pkg::*;
	logic        core_clk, srst, arm, next_xfer;             // Clock, reset, model control
	logic        start_instruction, halt_instruction, interrupt_ack_instruction;
	logic        start_accepted, start_refused, device_int_req, device_busy, irq;
	logic [7:0]  next_byte;                                  // Next order byte
	logic [1:0]  wait_n;                                     // Model stall
	logic [31:0] reg_rdata, seed, nbytes;                    // Read data, rng, data count
	int          err_total, samples_checked, cycles;         // Counters
	order_s      order;                                      // From the model
	svc_s        svc;                                        // To the model
	reg_req_s    reg_req;                                    // Register port

	service_order_decoder dut_u (.core_clk(core_clk), .srst(srst), .order(order), .svc(svc),
		.start_instruction(start_instruction), .halt_instruction(halt_instruction),
		.interrupt_ack_instruction(interrupt_ack_instruction),
		.start_accepted(start_accepted), .start_refused(start_refused),
		.device_int_req(device_int_req), .device_busy(device_busy),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
	iop_model model_u (.core_clk(core_clk), .srst(srst), .svc(svc), .arm(arm),
		.next_byte(next_byte), .next_xfer(next_xfer), .wait_n(wait_n), .order(order));

	// Free-running clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 8000) begin
			err_total = err_total + 1;
			stop_test();
		end
	end

	// Xorshift, fixed seed keeps runs repeatable
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected request struct for one service kind
	function automatic logic [31:0] exp_svc(svc_kind_e k, logic ce, logic ae);
		return {27'h0, k != SVC_NONE, k, ce, ae};
	endfunction

	// Single compare point
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
		#1;
	endtask

	// Read, data only in the following cycle
	task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
		@(posedge core_clk);
		reg_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Pulse start (0), halt (1) or acknowledge (2)
	task automatic instr(int w);
		@(posedge core_clk);
		{start_instruction, halt_instruction, interrupt_ack_instruction} <= 3'b100 >> w;
		@(posedge core_clk);
		{start_instruction, halt_instruction, interrupt_ack_instruction} <= 3'b000;
		#1;
	endtask

	// Let the model end the pending service cycle with one order
	task automatic ord(logic [7:0] b, logic x);
		@(posedge core_clk);
		next_byte <= b;
		next_xfer <= x;
		wait_n <= 2'(rnd());
		arm <= 1'b1;
		@(posedge core_clk);
		arm <= 1'b0;
		#1;
		for (int i = 0; i < 10 && order.valid !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		check(order.valid, 1'b1);
		@(posedge core_clk);
		#1;
	endtask

	// One operation from start to the ending picked by m
	task automatic op(int m);
		int          n;
		logic [31:0] r;
		wr(OFF_EVENTS, 32'h3F);
		instr(0);
		check(start_accepted, 1'b1);
		check(32'(svc), exp_svc(SVC_ORDER_OUT, 1'b0, 1'b0));
		nbytes = 0;
		ord(8'h00, 1'b0);
		n = 1 + int'(rnd() % 4);
		// Data orders with random chain and high bits, some dummies
		for (int i = 0; i < n; i++) begin
			r = rnd();
			nbytes = nbytes + r[8];
			ord(r[7:0] & 8'hF4, r[8]);
			check(32'(svc), exp_svc(SVC_DATA, 1'b0, 1'b0));
		end
		case (m)
			0: begin
				ord(8'h02, 1'b0);
				check(32'(svc), exp_svc(SVC_ORDER_IN, 1'b1, 1'b0));
				ord(8'hA0, 1'b0);
				check(32'(svc), exp_svc(SVC_NONE, 1'b0, 1'b0));
				check(device_busy, 1'b0);
				rd_chk(OFF_COUNT, nbytes);
				rd_chk(OFF_EVENTS, 32'h15);
			end
			1: begin
				ord(8'h02, 1'b0);
				ord(8'h05, 1'b0);
				check(32'(svc), exp_svc(SVC_ORDER_OUT, 1'b0, 1'b0));
				check(device_int_req, 1'b1);
				instr(2);
				ord(8'h00, 1'b0);
				check(32'(svc), exp_svc(SVC_DATA, 1'b0, 1'b0));
				ord(8'h02, 1'b0);
				ord(8'h00, 1'b0);
				check(device_busy, 1'b0);
			end
			2: begin
				ord(8'h02, 1'b0);
				ord(8'h01, 1'b0);
				check(32'(svc), exp_svc(SVC_NONE, 1'b0, 1'b0));
				check({device_int_req, irq}, 2'b11);
				instr(0);
				check({start_refused, start_accepted}, 2'b10);
				instr(2);
				check(device_int_req, 1'b0);
				wr(OFF_EVENTS, 32'h3F);
				check(irq, 1'b0);
			end
			3: begin
				ord(8'h08, 1'b0);
				check(32'(svc), exp_svc(SVC_ORDER_IN, 1'b1, 1'b1));
				ord(8'h00, 1'b0);
				check(device_busy, 1'b0);
			end
			4: begin
				ord(8'h02, 1'b0);
				ord(8'h0C, 1'b0);
				check(32'(svc), exp_svc(SVC_NONE, 1'b0, 1'b0));
				rd_chk(OFF_EVENTS, 32'h15);
			end
			default: begin
				ord(8'h01, 1'b0);
				check(32'(svc), exp_svc(SVC_DATA, 1'b0, 1'b0));
				check(device_int_req, 1'b1);
				instr(1);
				check(device_busy, 1'b0);
				instr(2);
			end
		endcase
	endtask

	// Verdict and end of run
	task automatic stop_test();
		$display("Checks %0d, errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{srst, arm, next_xfer, next_byte, wait_n} = {1'b1, 12'h000};
		{start_instruction, halt_instruction, interrupt_ack_instruction} = 3'b000;
		reg_req = '0;
		{seed, nbytes, err_total, samples_checked, cycles} = {32'd68722, 32'h0, 96'h0};
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		check(32'(svc), exp_svc(SVC_NONE, 1'b0, 1'b0));
		check(device_busy, 1'b0);
		rd_chk(OFF_CTRL, 32'(RST_ENABLE));
		rd_chk(OFF_MASK, 32'(RST_MASK));
		rd_chk(OFF_EVENTS, 32'h0);
		rd_chk(OFF_COUNT, 32'h0);
		rd_chk(8'h20, 32'h0);
		wr(OFF_MASK, 32'h1 << EV_INTR);
		for (int s = 0; s < 12; s++) begin
			op(s % 6);
		end
		// Disabled controller refuses; abort ends a busy operation
		wr(OFF_CTRL, 32'h0);
		instr(0);
		check({start_refused, start_accepted}, 2'b10);
		wr(OFF_CTRL, 32'h1);
		instr(0);
		check(start_accepted, 1'b1);
		ord(8'h00, 1'b0);
		wr(OFF_CTRL, 32'h3);
		check(32'(svc), exp_svc(SVC_ORDER_IN, 1'b1, 1'b1));
		rd_chk(OFF_STATE, 32'h4);
		ord(8'hF0, 1'b0);
		check(device_busy, 1'b0);
		rd_chk(OFF_STATE, 32'hF00);
		rd_chk(OFF_CTRL, 32'h1);
		stop_test();
	end
endmodule
